// file: logic/pc_stack_pkg.sv
// Constants, types and register map for the program-flow and addressing unit.
// Assumes one clock (the instruction cycle) and a synchronous active-high reset.
package pc_stack_pkg;
   localparam int PC_W = 15;
   localparam int SP_W = 5;
   localparam int STACK_DEPTH = 16;
   localparam int DADDR_W = 12;

   // Avalon byte addresses
   localparam logic [5:0] REG_COUNTER_LOW  = 6'h00;
   localparam logic [5:0] REG_HIGH_LATCH   = 6'h04;
   localparam logic [5:0] REG_STACK_PTR    = 6'h08;
   localparam logic [5:0] REG_TOP_LOW      = 6'h0c;
   localparam logic [5:0] REG_TOP_HIGH     = 6'h10;
   localparam logic [5:0] REG_PTR0_LOW     = 6'h14;
   localparam logic [5:0] REG_PTR0_HIGH    = 6'h18;
   localparam logic [5:0] REG_PTR1_LOW     = 6'h1c;
   localparam logic [5:0] REG_PTR1_HIGH    = 6'h20;
   localparam logic [5:0] REG_POWER_CTRL   = 6'h24;

   localparam int OVF_BIT      = 7;
   localparam int UNF_BIT      = 6;
   localparam int FAULT_EN_BIT = 9;

   localparam logic [4:0]  SP_EMPTY      = 5'h1f;
   localparam logic [4:0]  SP_FULL       = 5'h0f;
   localparam logic [15:0] TRAD_LAST     = 16'h0fff;
   localparam logic [15:0] LIN_BASE      = 16'h2000;
   localparam logic [15:0] LIN_LAST      = 16'h29af;
   localparam logic [11:0] GPR_BLOCK     = 12'h050;
   localparam logic [6:0]  GPR_BASE      = 7'h20;
   localparam logic [6:0]  IND_PORT_LAST = 7'h01;
   localparam int          FLASH_SEL_BIT = 15;

   typedef enum logic [3:0] {
      OP_NONE      = 4'b0000,
      OP_STEP      = 4'b0001,
      OP_WRITE_LOW = 4'b0010,
      OP_CALL      = 4'b0011,
      OP_COMPUTED_CALL_INSTR     = 4'b0100,
      OP_BRW       = 4'b0101,
      OP_BRA       = 4'b0110,
      OP_RETURN    = 4'b0111,
      OP_VECTOR    = 4'b1000
   } flow_op_e;

   typedef enum logic [1:0] {
      IND_IDLE   = 2'b00,
      IND_ACCESS = 2'b01,
      IND_FLASH  = 2'b10,
      IND_DONE   = 2'b11
   } ind_state_e;

   typedef enum logic [1:0] {
      MODE_DATA  = 2'b00,
      MODE_ZERO  = 2'b01,
      MODE_FLASH = 2'b10
   } ind_mode_e;

   typedef struct packed {
      flow_op_e    op;
      logic [10:0] operand;
      logic [7:0]  wreg;
      logic [7:0]  data;
   } flow_ctl_s;

   typedef struct packed {
      logic       valid;
      logic       sel;
      logic       write;
      logic [7:0] wdata;
   } ind_req_s;

   typedef struct packed {
      logic [11:0] addr;
      logic        re;
      logic        we;
      logic [7:0]  wdata;
   } dmem_s;
endpackage

// file: logic/pc_stack_indirect_addressing.sv
// Program counter, 16-level return stack and indirect addressing unit.
// Assumes a decoder driving one flow op per cycle and an Avalon-MM master.
module pc_stack_indirect_addressing
   import pc_stack_pkg::*;
#(
   parameter logic [14:0] VECTOR_ADDR = 15'h0004
) (
   // Clock and reset
   input  wire logic                mclk_in,
   input  wire logic                sys_rst_in,
   // Configuration
   input  wire logic [13:0]         cfg_word2_in,
   // Decoder flow control
   input  wire flow_ctl_s           flow_ctl_in,
   output logic      [PC_W-1:0]     pc_out,
   output logic                     fault_reset_out,
   // Indirect access request and answer
   input  wire ind_req_s            ind_req_in,
   output logic                     ind_ready_out,
   output logic                     ind_ack_out,
   output logic      [7:0]          ind_rdata_out,
   // Data and flash memory ports
   output dmem_s                    dmem_out,
   input  wire logic [7:0]          dmem_rdata_in,
   output logic      [PC_W-1:0]     fmem_addr_out,
   input  wire logic [13:0]         fmem_rdata_in,
   // Avalon-MM slave
   input  wire logic [5:0]          avs_address_in,
   input  wire logic                avs_read_in,
   input  wire logic                avs_write_in,
   input  wire logic [31:0]         avs_writedata_in,
   output logic      [31:0]         avs_readdata_out,
   output logic                     avs_waitrequest_out
);

   typedef struct packed {
      logic [PC_W-1:0]                   pc;
      logic [6:0]                        latch;
      logic [SP_W-1:0]                   sp;
      logic [STACK_DEPTH-1:0][PC_W-1:0]  stack;
      logic [15:0]                       ptr0;
      logic [15:0]                       ptr1;
      logic                              ovf;
      logic                              unf;
      logic                              fault_en;
      logic                              fault_pulse;
      ind_state_e                        ist;
      ind_mode_e                         mode;
      dmem_s                             dmem;
      logic [PC_W-1:0]                   faddr;
      logic [7:0]                        ind_rdata;
      logic                              rd_valid;
      logic [31:0]                       readdata;
   } state_s;

   state_s s;
   state_s next_s;

   logic [31:0]     rd_word;
   logic [PC_W-1:0] pc_inc;
   logic [PC_W-1:0] push_val;
   logic            push;
   logic            pop;
   logic [14:0]     top_entry;
   logic [15:0]     ptr;
   logic [15:0]     lin_off;
   logic [11:0]     lin_bank;
   logic [11:0]     lin_in;

   always_comb begin
      next_s = s;
      next_s.fault_pulse = 1'b0;
      next_s.fault_en = cfg_word2_in[FAULT_EN_BIT];
      // Empty stack with fault reset reads zero, otherwise the wrapped slot
      top_entry = s.stack[s.sp[3:0]];
      if (s.sp == SP_EMPTY && s.fault_en) begin
         top_entry = '0;
      end

      // Register read mux
      rd_word = '0;
      case (avs_address_in)
         REG_COUNTER_LOW: rd_word[7:0] = s.pc[7:0];
         REG_HIGH_LATCH:  rd_word[6:0] = s.latch;
         REG_STACK_PTR:   rd_word[4:0] = s.sp;
         REG_TOP_LOW:     rd_word[7:0] = top_entry[7:0];
         REG_TOP_HIGH:    rd_word[6:0] = top_entry[14:8];
         REG_PTR0_LOW:    rd_word[7:0] = s.ptr0[7:0];
         REG_PTR0_HIGH:   rd_word[7:0] = s.ptr0[15:8];
         REG_PTR1_LOW:    rd_word[7:0] = s.ptr1[7:0];
         REG_PTR1_HIGH:   rd_word[7:0] = s.ptr1[15:8];
         REG_POWER_CTRL: begin
            rd_word[OVF_BIT] = s.ovf;
            rd_word[UNF_BIT] = s.unf;
         end
         default:         rd_word = '0;
      endcase
      // One wait state on reads so read data comes from a flop
      next_s.rd_valid = avs_read_in & ~s.rd_valid;
      if (avs_read_in && !s.rd_valid) begin
         next_s.readdata = rd_word;
      end

      if (avs_write_in) begin
         case (avs_address_in)
            REG_COUNTER_LOW: next_s.pc = {s.latch, avs_writedata_in[7:0]};
            REG_HIGH_LATCH:  next_s.latch = avs_writedata_in[6:0];
            REG_STACK_PTR:   next_s.sp = avs_writedata_in[4:0];
            REG_TOP_LOW:     next_s.stack[s.sp[3:0]][7:0] = avs_writedata_in[7:0];
            REG_TOP_HIGH:    next_s.stack[s.sp[3:0]][14:8] = avs_writedata_in[6:0];
            REG_PTR0_LOW:    next_s.ptr0[7:0] = avs_writedata_in[7:0];
            REG_PTR0_HIGH:   next_s.ptr0[15:8] = avs_writedata_in[7:0];
            REG_PTR1_LOW:    next_s.ptr1[7:0] = avs_writedata_in[7:0];
            REG_PTR1_HIGH:   next_s.ptr1[15:8] = avs_writedata_in[7:0];
            REG_POWER_CTRL: begin
               // Writing zero clears; a hardware set later in this cycle wins
               next_s.ovf = s.ovf & avs_writedata_in[OVF_BIT];
               next_s.unf = s.unf & avs_writedata_in[UNF_BIT];
            end
            default: next_s.pc = next_s.pc;
         endcase
      end

      // Program flow; decoder wins over a same-cycle bus write
      pc_inc = s.pc + 15'h0001;
      push = 1'b0;
      pop = 1'b0;
      push_val = pc_inc;
      case (flow_ctl_in.op)
         OP_STEP:      next_s.pc = pc_inc;
         OP_WRITE_LOW: next_s.pc = {s.latch, flow_ctl_in.data};
         OP_CALL: begin
            next_s.pc = {s.latch[6:3], flow_ctl_in.operand};
            push = 1'b1;
         end
         OP_COMPUTED_CALL_INSTR: begin
            next_s.pc = {s.latch, flow_ctl_in.wreg};
            push = 1'b1;
         end
         OP_BRW:       next_s.pc = pc_inc + {7'h00, flow_ctl_in.wreg};
         OP_BRA:       next_s.pc = pc_inc + {{6{flow_ctl_in.operand[8]}},
                                             flow_ctl_in.operand[8:0]};
         OP_RETURN:    pop = 1'b1;
         OP_VECTOR: begin
            next_s.pc = VECTOR_ADDR;
            push = 1'b1;
            push_val = s.pc;
         end
         default:      next_s.pc = next_s.pc;
      endcase

      if (push) begin
         if (s.sp == SP_FULL) begin
            next_s.ovf = 1'b1;
         end
         if (s.sp == SP_FULL && s.fault_en) begin
            next_s.fault_pulse = 1'b1;
         end else begin
            next_s.sp = s.sp + 5'h01;
            next_s.stack[next_s.sp[3:0]] = push_val;
         end
      end
      if (pop) begin
         if (s.sp == SP_EMPTY) begin
            next_s.unf = 1'b1;
         end
         if (s.sp == SP_EMPTY && s.fault_en) begin
            next_s.fault_pulse = 1'b1;
         end else begin
            next_s.pc = s.stack[s.sp[3:0]];
            next_s.sp = s.sp - 5'h01;
         end
      end
      // Fault reset restarts flow but keeps the flags for software to see
      if (next_s.fault_pulse) begin
         next_s.pc = '0;
         next_s.sp = SP_EMPTY;
      end

      // Indirect access decode
      ptr = ind_req_in.sel ? s.ptr1 : s.ptr0;
      lin_off = ptr - LIN_BASE;
      lin_bank = lin_off[11:0] / GPR_BLOCK;
      lin_in = lin_off[11:0] % GPR_BLOCK;
      next_s.dmem.re = 1'b0;
      next_s.dmem.we = 1'b0;
      case (s.ist)
         IND_IDLE: begin
            if (ind_req_in.valid) begin
               next_s.ist = IND_ACCESS;
               next_s.dmem.wdata = ind_req_in.wdata;
               next_s.faddr = ptr[14:0];
               next_s.mode = MODE_ZERO;
               next_s.dmem.addr = '0;
               if (ptr[FLASH_SEL_BIT]) begin
                  next_s.mode = MODE_FLASH;
               end else if (ptr <= TRAD_LAST) begin
                  next_s.dmem.addr = ptr[11:0];
                  // Indirect ports sit at the first two bytes of each bank
                  if (ptr[6:0] > IND_PORT_LAST) begin
                     next_s.mode = MODE_DATA;
                  end
               end else if (ptr >= LIN_BASE && ptr <= LIN_LAST) begin
                  next_s.dmem.addr = {lin_bank[4:0], GPR_BASE + lin_in[6:0]};
                  next_s.mode = MODE_DATA;
               end
               if (next_s.mode == MODE_DATA) begin
                  next_s.dmem.re = ~ind_req_in.write;
                  next_s.dmem.we = ind_req_in.write;
               end
            end
         end
         IND_ACCESS: begin
            case (s.mode)
               MODE_FLASH: next_s.ist = IND_FLASH;
               MODE_DATA: begin
                  next_s.ind_rdata = dmem_rdata_in;
                  next_s.ist = IND_DONE;
               end
               default: begin
                  next_s.ind_rdata = '0;
                  next_s.ist = IND_DONE;
               end
            endcase
         end
         IND_FLASH: begin
            next_s.ind_rdata = fmem_rdata_in[7:0];
            next_s.ist = IND_DONE;
         end
         IND_DONE:  next_s.ist = IND_IDLE;
         default:   next_s.ist = IND_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         s <= '{pc: '0, sp: SP_EMPTY, ist: IND_IDLE, mode: MODE_ZERO,
                default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign pc_out = s.pc;
   assign fault_reset_out = s.fault_pulse;
   assign ind_ready_out = (s.ist == IND_IDLE);
   assign ind_ack_out = (s.ist == IND_DONE);
   assign ind_rdata_out = s.ind_rdata;
   assign dmem_out = s.dmem;
   assign fmem_addr_out = s.faddr;
   assign avs_readdata_out = s.readdata;
   assign avs_waitrequest_out = avs_read_in & ~s.rd_valid;

   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   logic op_ok;
   assign op_ok = !avs_write_in;

   // Reset is checked while it is applied, so it needs its own disable
   a_reset_clears_pc: assert property (@(posedge mclk_in) disable iff (1'b0)
      sys_rst_in |=> pc_out == '0 && s.sp == SP_EMPTY && !fault_reset_out)
      else $error("pc or pointer not cleared by reset");

   // Counter loading
   a_low_write_load: assert property (flow_ctl_in.op == OP_WRITE_LOW |=>
      pc_out == {$past(s.latch), $past(flow_ctl_in.data)})
      else $error("low byte write did not merge latch");
   a_bus_low_write: assert property (avs_write_in && avs_address_in == REG_COUNTER_LOW &&
      flow_ctl_in.op == OP_NONE |=> pc_out == {$past(s.latch), $past(avs_writedata_in[7:0])})
      else $error("bus low byte write did not merge latch");
   a_step_count: assert property (flow_ctl_in.op == OP_STEP |=>
      pc_out == $past(s.pc) + 15'h0001) else $error("step did not advance counter");
   a_call_target: assert property (flow_ctl_in.op == OP_CALL && s.sp != SP_FULL |=>
      pc_out == {$past(s.latch[6:3]), $past(flow_ctl_in.operand)} &&
      s.stack[s.sp[3:0]] == $past(s.pc) + 15'h0001)
      else $error("call target or pushed address wrong");
   a_computed_call_instr_target: assert property (flow_ctl_in.op == OP_COMPUTED_CALL_INSTR && s.sp != SP_FULL |=>
      pc_out == {$past(s.latch), $past(flow_ctl_in.wreg)})
      else $error("computed call target wrong");
   a_brw_target: assert property (flow_ctl_in.op == OP_BRW |=>
      pc_out == $past(s.pc) + 15'h0001 + {7'h00, $past(flow_ctl_in.wreg)})
      else $error("branch by W target wrong");
   a_bra_target: assert property (flow_ctl_in.op == OP_BRA |=>
      pc_out == $past(s.pc) + 15'h0001 + {{6{$past(flow_ctl_in.operand[8])}},
      $past(flow_ctl_in.operand[8:0])}) else $error("relative branch target wrong");

   // Return stack
   a_vector_push: assert property (flow_ctl_in.op == OP_VECTOR && s.sp != SP_FULL |=>
      pc_out == VECTOR_ADDR && s.stack[s.sp[3:0]] == $past(s.pc))
      else $error("vectoring did not push current counter");
   a_latch_kept: assert property ((push || pop) && !avs_write_in |=>
      s.latch == $past(s.latch)) else $error("push or pop changed the latch");
   a_push_pointer: assert property (push && s.sp != SP_FULL |=>
      s.sp == $past(s.sp) + 5'h01) else $error("push did not advance pointer");
   a_pop_returns: assert property (pop && s.sp != SP_EMPTY && op_ok |=>
      pc_out == $past(s.stack[s.sp[3:0]]) && s.sp == $past(s.sp) - 5'h01)
      else $error("pop returned wrong address");
   a_stack_wrap: assert property (push && s.sp == SP_FULL && !s.fault_en |=>
      s.sp[3:0] == 4'h0 && s.stack[0] == $past(push_val) && !fault_reset_out)
      else $error("overflowing push did not wrap to the first entry");
   a_overflow_flag: assert property (push && s.sp == SP_FULL |=> s.ovf)
      else $error("overflow flag not set");
   a_underflow_flag: assert property (pop && s.sp == SP_EMPTY |=> s.unf)
      else $error("underflow flag not set");
   a_flag_clear: assert property (avs_write_in && avs_address_in == REG_POWER_CTRL &&
      !avs_writedata_in[UNF_BIT] && !pop |=> !s.unf)
      else $error("underflow flag not cleared by software");
   a_overflow_fault: assert property (push && s.sp == SP_FULL && s.fault_en |=>
      fault_reset_out && s.ovf && pc_out == '0 && s.sp == SP_EMPTY)
      else $error("overflow fault reset missing");
   a_fault_reset: assert property (pop && s.sp == SP_EMPTY && s.fault_en |=>
      fault_reset_out && s.unf && pc_out == '0)
      else $error("underflow fault reset missing");
   a_fault_enable: assert property (1'b1 |=>
      s.fault_en == $past(cfg_word2_in[FAULT_EN_BIT])) else $error("fault enable not sampled");
   a_top_empty: assert property (s.sp == SP_EMPTY && s.fault_en && avs_read_in &&
      avs_address_in == REG_TOP_LOW && avs_waitrequest_out |=> avs_readdata_out == '0)
      else $error("empty stack top not read as zero");

   // Register bus and indirect access
   a_read_wait: assert property (avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("read wait state longer than one cycle");
   a_ptr_write: assert property (avs_write_in && avs_address_in == REG_PTR0_HIGH |=>
      s.ptr0[15:8] == $past(avs_writedata_in[7:0])) else $error("pointer high byte not stored");
   a_trad_map: assert property (ind_ready_out && ind_req_in.valid && ptr <= TRAD_LAST |=>
      dmem_out.addr == $past(ptr[11:0])) else $error("traditional address not direct");
   a_flash_extra: assert property (ind_ready_out && ind_req_in.valid &&
      (ind_req_in.sel ? s.ptr1[15] : s.ptr0[15]) |=> !ind_ack_out ##1 !ind_ack_out
      ##1 ind_ack_out) else $error("flash access not three cycles");
   a_data_ack: assert property (ind_ready_out && ind_req_in.valid &&
      !(ind_req_in.sel ? s.ptr1[15] : s.ptr0[15]) |=> !ind_ack_out ##1 ind_ack_out)
      else $error("data access not two cycles");
   a_self_ref_zero: assert property (s.ist == IND_ACCESS && s.mode == MODE_ZERO |=>
      ind_rdata_out == 8'h00) else $error("refused indirect read not zero");
   a_flash_data: assert property (s.ist == IND_FLASH |=>
      ind_rdata_out == $past(fmem_rdata_in[7:0])) else $error("flash low byte not returned");
   a_flash_no_write: assert property (s.mode != MODE_DATA |-> !dmem_out.we)
      else $error("write reached memory from non-data region");

   c_call_return: cover property (flow_ctl_in.op == OP_CALL ##[1:20]
      flow_ctl_in.op == OP_RETURN);
   c_stack_wrap: cover property (push && s.sp == SP_FULL && !s.fault_en);
   c_flash_read: cover property (s.ist == IND_FLASH ##1 ind_ack_out);
   c_fault_reset: cover property (fault_reset_out);
   c_indirect_write: cover property (s.ist == IND_ACCESS && dmem_out.we);

endmodule

// file: testbench/pc_stack_indirect_addressing_test.sv
// Self-checking bench for the program-flow, return stack and indirect unit.
// Assumes the unit's package types, its Avalon slave and its hand-over timing.
module pc_stack_indirect_addressing_test import pc_stack_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic            mclk_in          = 1'b0;
   logic            sys_rst_in       = 1'b1;
   logic [13:0]     cfg_word2_in     = 14'h0;
   flow_ctl_s       flow_ctl_in      = '0;
   ind_req_s        ind_req_in       = '0;
   logic [5:0]      avs_address_in   = 6'h0;
   logic            avs_read_in      = 1'b0;
   logic            avs_write_in     = 1'b0;
   logic [31:0]     avs_writedata_in = 32'h0;
   logic            pc_probe         = 1'b0;
   logic [PC_W-1:0] pc_out;
   logic [PC_W-1:0] fmem_addr_out;
   logic            fault_reset_out;
   logic            ind_ready_out;
   logic            ind_ack_out;
   logic            avs_waitrequest_out;
   logic [7:0]      ind_rdata_out;
   logic [7:0]      dmem_rdata_in;
   logic [13:0]     fmem_rdata_in;
   logic [31:0]     avs_readdata_out;
   dmem_s           dmem_out;
   logic [7:0]      mem [4096];
   logic [31:0]     q_bus [$];
   logic [31:0]     q_pc [$];
   logic [8:0]      q_ind [$];
   int              mismatches  = 0;
   int              comparisons = 0;
   int              faults      = 0;
   int              writes      = 0;

   // Idle read port shows inverted data so a late sample cannot pass
   assign dmem_rdata_in = dmem_out.re ? mem[dmem_out.addr] : ~mem[dmem_out.addr];
   assign fmem_rdata_in = {fmem_addr_out[13:8], fmem_addr_out[7:0] ^ 8'h5a};

   initial forever #4 mclk_in = ~mclk_in;

   pc_stack_indirect_addressing uut (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cfg_word2_in(cfg_word2_in),
      .flow_ctl_in(flow_ctl_in), .pc_out(pc_out), .fault_reset_out(fault_reset_out),
      .ind_req_in(ind_req_in), .ind_ready_out(ind_ready_out), .ind_ack_out(ind_ack_out),
      .ind_rdata_out(ind_rdata_out), .dmem_out(dmem_out), .dmem_rdata_in(dmem_rdata_in),
      .fmem_addr_out(fmem_addr_out), .fmem_rdata_in(fmem_rdata_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   always @(posedge mclk_in) begin
      logic [8:0] note;
      if (fault_reset_out === 1'b1) faults++;
      if (dmem_out.we === 1'b1) begin
         writes++;
         mem[dmem_out.addr] <= dmem_out.wdata;
      end
      if (avs_read_in && avs_waitrequest_out === 1'b0)
         check(avs_readdata_out, q_bus.pop_front(), "bus read");
      if (pc_probe) check(32'(pc_out), q_pc.pop_front(), "counter");
      if (ind_ack_out === 1'b1 && q_ind.size() > 0) begin
         note = q_ind.pop_front();
         if (note[8]) check(32'(ind_rdata_out), 32'(note[7:0]), "indirect read");
      end
   end

   // Waits for the slave however long it takes; only the watchdog ends a hang
   task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= w;
      avs_read_in <= !w;
      do begin
         @(posedge mclk_in);
      end while (avs_waitrequest_out !== 1'b0);
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge mclk_in);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      q_bus.push_back(e);
      bus(a, 1'b0, 32'h0);
   endtask

   task automatic op(input flow_op_e o, input logic [10:0] x, input logic [7:0] w);
      flow_ctl_in <= '{o, x, w, w};
      @(posedge mclk_in);
      flow_ctl_in.op <= OP_NONE;
      @(posedge mclk_in);
   endtask

   task automatic pc_is(input logic [14:0] e);
      q_pc.push_back(32'(e));
      pc_probe <= 1'b1;
      @(posedge mclk_in);
      pc_probe <= 1'b0;
      @(posedge mclk_in);
   endtask

   task automatic ptr(input logic s, input logic [15:0] v);
      wr(s ? REG_PTR1_LOW : REG_PTR0_LOW, 32'(v[7:0]));
      wr(s ? REG_PTR1_HIGH : REG_PTR0_HIGH, 32'(v[15:8]));
   endtask

   // Latency is counted from the taking edge to the edge that samples ack
   task automatic ind(input logic s, input logic w, input logic [7:0] d,
                      input logic [8:0] note, input int lat);
      int n;
      n = 0;
      q_ind.push_back(note);
      ind_req_in <= '{1'b1, s, w, d};
      do begin
         @(posedge mclk_in);
         n++;
      end while (ind_ready_out !== 1'b1);
      ind_req_in.valid <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
      end while (ind_ack_out !== 1'b1);
      check(32'(n), 32'(lat), "indirect latency");
   endtask

   task automatic cfg(input logic en);
      cfg_word2_in <= (14'($urandom) & 14'h3dff) | {4'h0, en, 9'h0};
      repeat (2) @(posedge mclk_in);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk_in);
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end

   initial begin
      logic [14:0] p, r1, r2, fa;
      logic [7:0]  w, v;
      logic [6:0]  lv;
      logic [10:0] x;
      logic [11:0] n, a;
      logic [15:0] bad [4];
      int          k;
      k = $urandom(96037);
      bad = '{16'h1800, 16'h29b0, 16'h0081, 16'h0f00};
      foreach (mem[i]) mem[i] = 8'($urandom);
      repeat (20) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(posedge mclk_in);
      cfg(1'b0);
      pc_is(15'h0);
      rd(REG_STACK_PTR, 32'h1f);
      rd(REG_POWER_CTRL, 32'h0);
      $display("reset values done");

      lv = 7'($urandom);
      wr(REG_HIGH_LATCH, {25'h1ffffff, lv});
      rd(REG_HIGH_LATCH, 32'(lv));
      wr(REG_COUNTER_LOW, 32'hc3);
      pc_is({lv, 8'hc3});
      rd(REG_COUNTER_LOW, 32'hc3);
      op(OP_WRITE_LOW, 11'h0, 8'h17);
      pc_is({lv, 8'h17});
      op(OP_WRITE_LOW, 11'h0, 8'hc3);
      op(OP_STEP, 11'h0, 8'h0);
      pc_is({lv, 8'hc4});
      $display("counter writes done");

      p = {lv, 8'hc4};
      x = 11'($urandom);
      op(OP_CALL, x, 8'h0);
      r1 = p + 15'd1;
      p = {lv[6:3], x};
      pc_is(p);
      rd(REG_STACK_PTR, 32'h0);
      rd(REG_TOP_LOW, 32'(r1[7:0]));
      rd(REG_TOP_HIGH, 32'(r1[14:8]));
      w = 8'($urandom);
      op(OP_COMPUTED_CALL_INSTR, 11'h0, w);
      r2 = p + 15'd1;
      p = {lv, w};
      pc_is(p);
      rd(REG_HIGH_LATCH, 32'(lv));
      w = 8'($urandom) | 8'h80;
      op(OP_BRW, 11'h0, w);
      p = p + 15'd1 + 15'(w);
      pc_is(p);
      x = 11'($urandom) | 11'h100;
      op(OP_BRA, x, 8'h0);
      p = p + 15'd1 + {{6{x[8]}}, x[8:0]};
      pc_is(p);
      op(OP_RETURN, 11'h0, 8'h0);
      pc_is(r2);
      rd(REG_STACK_PTR, 32'h0);
      op(OP_RETURN, 11'h0, 8'h0);
      pc_is(r1);
      op(OP_VECTOR, 11'h0, 8'h0);
      pc_is(15'h0004);
      op(OP_RETURN, 11'h0, 8'h0);
      pc_is(r1);
      rd(REG_STACK_PTR, 32'h1f);
      $display("calls and branches done");

      wr(REG_STACK_PTR, 32'h0f);
      wr(REG_TOP_LOW, 32'h5a);
      wr(REG_TOP_HIGH, 32'h21);
      wr(REG_STACK_PTR, 32'h1f);
      rd(REG_TOP_LOW, 32'h5a);
      op(OP_RETURN, 11'h0, 8'h0);
      pc_is(15'h215a);
      rd(REG_POWER_CTRL, 32'h40);
      wr(REG_POWER_CTRL, 32'h0);
      wr(REG_STACK_PTR, 32'h0f);
      op(OP_CALL, 11'h7ff, 8'h0);
      rd(REG_STACK_PTR, 32'h10);
      rd(REG_TOP_LOW, 32'h5b);
      rd(REG_POWER_CTRL, 32'h80);
      $display("stack wrap done");

      // Reset in mid-run with the counter, pointer and overflow flag non-zero
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(posedge mclk_in);
      pc_is(15'h0);
      rd(REG_STACK_PTR, 32'h1f);
      rd(REG_HIGH_LATCH, 32'h0);
      rd(REG_POWER_CTRL, 32'h0);
      $display("second reset done");

      cfg(1'b1);
      wr(REG_STACK_PTR, 32'h1f);
      rd(REG_TOP_LOW, 32'h0);
      wr(REG_POWER_CTRL, 32'h0);
      wr(REG_STACK_PTR, 32'h0f);
      k = faults;
      op(OP_CALL, 11'h123, 8'h0);
      pc_is(15'h0);
      rd(REG_STACK_PTR, 32'h1f);
      rd(REG_POWER_CTRL, 32'h80);
      op(OP_RETURN, 11'h0, 8'h0);
      pc_is(15'h0);
      rd(REG_POWER_CTRL, 32'hc0);
      check(32'(faults - k), 32'd2, "fault pulses");
      cfg(1'b0);
      $display("fault reset done");

      ptr(1'b0, 16'h0123);
      ind(1'b0, 1'b0, 8'h0, {1'b1, mem[12'h123]}, 2);
      n = 12'($urandom % 2480);
      a = {5'(n / 12'd80), 7'(12'h20 + n % 12'd80)};
      ptr(1'b1, 16'h2000 + 16'(n));
      ind(1'b1, 1'b0, 8'h0, {1'b1, mem[a]}, 2);
      v = 8'($urandom);
      ind(1'b1, 1'b1, v, 9'h0, 2);
      ptr(1'b0, {4'h0, a});
      ind(1'b0, 1'b0, 8'h0, {1'b1, v}, 2);
      foreach (bad[i]) begin
         ptr(1'b0, bad[i]);
         k = writes;
         ind(1'b0, 1'b0, 8'h0, 9'h100, 2);
         ind(1'b0, 1'b1, 8'hff, 9'h0, 2);
         check(32'(writes - k), 32'd0, "dropped write");
      end
      fa = 15'($urandom);
      ptr(1'b1, {1'b1, fa});
      rd(REG_PTR1_HIGH, {24'h0, 1'b1, fa[14:8]});
      k = writes;
      ind(1'b1, 1'b0, 8'h0, {1'b1, fa[7:0] ^ 8'h5a}, 3);
      ind(1'b1, 1'b1, v, 9'h0, 3);
      check(32'(writes - k), 32'd0, "flash write");
      $display("indirect access done");

      wr(6'h3c, 32'hff);
      rd(6'h3c, 32'h0);
      $display("unmapped access done");
      finish_test();
   end
endmodule
